/* design/aps_pkg.sv */
// Package for the always-on power sequencer register block
package aps_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int APS_ADDR_W = 8;
  localparam logic [APS_ADDR_W-1:0] APS_LOW_POWER_CONTROL = 8'h00;
  localparam logic [APS_ADDR_W-1:0] APS_GPIO0_WAKE_FLAGS = 8'h04;
  localparam logic [APS_ADDR_W-1:0] APS_GPIO0_WAKE_ENABLE = 8'h08;
  // Listed words held outside this block: read zero, writes dropped
  localparam logic [APS_ADDR_W-1:0] APS_GPIO1_WAKE_FLAGS = 8'h0c;
  localparam logic [APS_ADDR_W-1:0] APS_GPIO1_WAKE_ENABLE = 8'h10;
  localparam logic [APS_ADDR_W-1:0] APS_PERIPHERAL_WAKE_FLAGS = 8'h30;
  localparam logic [APS_ADDR_W-1:0] APS_PERIPHERAL_WAKE_ENABLE = 8'h34;
  localparam logic [APS_ADDR_W-1:0] APS_RAM_BANK_SHUTDOWN = 8'h40;
  localparam logic [APS_ADDR_W-1:0] APS_SCRATCH_WORD_A = 8'h48;
  localparam logic [APS_ADDR_W-1:0] APS_SCRATCH_WORD_B = 8'h4c;

  // ************************************************************
  // Low-power control fields and reset values
  // ************************************************************
  localparam int APS_CRYSTAL_OSC_POWERDOWN = 31;
  localparam int APS_CRYSTAL_KEEP = 29;
  localparam int APS_LFO_KEEP = 28;
  localparam int APS_IO_MON_OFF = 25;
  localparam int APS_ANALOG_MON_OFF = 22;
  localparam int APS_CORE_MON_OFF = 20;
  localparam int APS_CORE_EXT_SUPPLY = 17;
  localparam int APS_REGULATOR_OFF = 16;
  localparam int APS_CORE_POR_CUT = 12;
  localparam int APS_BANDGAP_OFF_IN_SLEEP = 11;
  localparam int APS_FAST_WAKE = 10;
  localparam int APS_STORAGE_EN = 9;
  localparam int APS_RET_SUPPLY_SEL = 8;
  localparam int APS_DET_BYPASS = 6;
  localparam int APS_RANGE_LSB = 4;
  localparam int APS_KEEP_LSB = 0;
  localparam logic [31:0] APS_LPC_WRITE_MASK = 32'hb2531f7f;
  localparam logic [31:0] APS_LPC_RESET = 32'h80011920;
  localparam logic [31:0] APS_WAKE_RESET = 32'h00000000;
  // Pins that exist; value arbitrary, all present by default
  localparam logic [31:0] APS_GPIO0_PRESENT = 32'hffffffff;
  // Cycles after reset before the core supply pin is judged
  localparam logic [3:0] APS_DETECT_CYCLES = 4'h4;
  localparam logic [1:0] APS_RESP_OKAY = 2'h0;
  localparam logic [1:0] APS_RESP_SLVERR = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    APS_PH_DETECT = 2'b01,
    APS_PH_RUN = 2'b10
  } aps_phase_t;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } aps_axi_req_t;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aps_axi_rsp_t;

  // Sequencer mode inputs, same clock
  typedef struct packed {
    logic low_power_active;
    logic deep_sleep_mode;
    logic mode_a_active;
    logic mode_a_request;
  } aps_mode_t;

  // Analog and sequencer controls
  typedef struct packed {
    logic crystal_osc_powerdown;
    logic crystal_keep_in_sleep;
    logic lfo_keep_in_sleep;
    logic lfo_force_off;
    logic io_monitor_off;
    logic analog_monitor_off;
    logic core_monitor_off;
    logic baud_rate_oscillator_off;
    logic core_ext_supply;
    logic regulator_off;
    logic core_por_cut;
    logic bandgap_off;
    logic skip_lfo_warmup;
    logic short_warmup;
    logic resume_next;
    logic reset_on_exit;
    logic enter_storage;
    logic enter_mode_a;
    logic ret_supply_sel;
    logic detect_bypass;
    logic [1:0] core_range;
    logic [7:0] bank_keep;
  } aps_ctrl_t;

  typedef struct packed {
    logic [31:0] meta;
    logic [31:0] stable;
  } aps_sync_state_t;

  typedef struct packed {
    logic [31:0] prev;
    logic [31:0] flags;
  } aps_wake_state_t;

  typedef struct packed {
    logic [31:0] lpc;
    logic [31:0] wake_en;
    aps_phase_t phase;
    logic [3:0] det_cnt;
    logic aw_have;
    logic [APS_ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aps_top_state_t;

endpackage : aps_pkg

/* design/aps_regs.sv */
// Always-on power sequencer register block with AXI4-Lite access
// Functional notes
// - Registers reset only by power-on reset
// - Bit 31 powers down crystal oscillator
// - Bit 29 keeps crystal running; storage overrides
// - Bit 28 keeps LF oscillator; storage forces off
// - Bits 25, 22 disable I/O, analog monitors
// - Bit 20 core monitor, baud oscillator off while bit 11 clear
// - Regulator bit cleared at power-up when no core supply
// - Bit 12 cuts core POR in sleep
// - Bit 11 bandgap off in deep sleep
// - Fast wake skips warm-ups, resumes next instruction
// - Without fast wake, exit acts as reset
// - Storage bit turns mode_a request into storage
// - Bit 8 selects RAM retention supply
// - Bit 6 bypasses core supply detection
// - Bits 5:4 pick core voltage, oscillator
// - Bits 3:0 keep RAM bank pairs
// - Bank 0 never kept across mode_a
// - Wake flags set by pins, write-one-clear
// - Enabled set flag wakes device
// - Enable bits gate wake; absent pins ignored
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module aps_regs (
  // Clock and power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register port
  input wire aps_pkg::aps_axi_req_t axi_req,
  output aps_pkg::aps_axi_rsp_t axi_rsp,
  // Sequencer mode, same clock
  input wire aps_pkg::aps_mode_t mode,
  // Pins: GPIO0 and core supply presence
  input wire logic [31:0] gpio0_pins,
  input wire logic core_supply_present,
  // Controls out
  output aps_pkg::aps_ctrl_t ctrl,
  // Wake to the sequencer
  output logic pin_wake
);
  import aps_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  aps_top_state_t s_q; // Whole block state
  aps_top_state_t s_d; // Next state
  logic [31:0] gpio0_sync; // Synchronised GPIO0
  logic [31:0] supply_sync; // Synchronised supply pin in bit 0
  logic [31:0] pin_wake_flags; // Wake flag word
  logic [31:0] flag_clear; // W1C bits for the flag word
  logic do_write; // Write committed this cycle
  logic do_read; // Read taken this cycle
  logic [APS_ADDR_W-1:0] raddr; // Read address
  logic [31:0] lpc; // Short name for the control word

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_mask

  // Merge written bytes into a word, keeping unwritable bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m = strb_mask(strb) & wmask;
    return (old & ~m) | (wd & m);
  endfunction : merge

  // Address is one of the listed words, including those held outside this block
  function automatic logic mapped(input logic [APS_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      APS_LOW_POWER_CONTROL, APS_GPIO0_WAKE_FLAGS, APS_GPIO0_WAKE_ENABLE,
      APS_GPIO1_WAKE_FLAGS, APS_GPIO1_WAKE_ENABLE, APS_PERIPHERAL_WAKE_FLAGS,
      APS_PERIPHERAL_WAKE_ENABLE, APS_RAM_BANK_SHUTDOWN, APS_SCRATCH_WORD_A,
      APS_SCRATCH_WORD_B:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction : mapped

  // ************************************************************
  // Pin synchronisers and wake flags
  // ************************************************************
  // GPIO0 pins into the clock domain
  aps_sync u_sync_gpio (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_async(gpio0_pins),
    .pin_sync(gpio0_sync)
  );

  // Core supply presence pin into the clock domain
  aps_sync u_sync_supply (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_async({31'h00000000, core_supply_present}),
    .pin_sync(supply_sync)
  );

  // Flag word and wake request
  aps_wake u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(gpio0_sync),
    .low_power_active(mode.low_power_active),
    .clear_bits(flag_clear),
    .enable_bits(s_q.wake_en),
    .pin_wake_flags(pin_wake_flags),
    .wake(pin_wake)
  );

  // ************************************************************
  // Bus decode
  // ************************************************************
  // Write commits once both address and data are held
  assign do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign do_read = axi_req.arvalid && !s_q.rvalid;
  assign raddr = axi_req.araddr[APS_ADDR_W-1:0];
  assign lpc = s_q.lpc;

  assign flag_clear = (do_write && s_q.awaddr == APS_GPIO0_WAKE_FLAGS) ?
                      (s_q.wdata & strb_mask(s_q.wstrb)) : 32'h00000000;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    // Write address channel
    if (axi_req.awvalid && !s_q.aw_have && !s_q.bvalid)
    begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = axi_req.awaddr[APS_ADDR_W-1:0];
    end
    // Write data channel
    if (axi_req.wvalid && !s_q.w_have && !s_q.bvalid)
    begin
      s_d.w_have = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    // Power-up check of the core supply pin
    case (s_q.phase)
      APS_PH_DETECT:
      begin
        if (s_q.det_cnt == APS_DETECT_CYCLES)
        begin
          s_d.phase = APS_PH_RUN;
          if (!supply_sync[0])
          begin
            s_d.lpc[APS_REGULATOR_OFF] = 1'b0;
          end
        end
        else
        begin
          s_d.det_cnt = s_q.det_cnt + 4'h1;
        end
      end
      APS_PH_RUN:
      begin
        s_d.phase = APS_PH_RUN;
      end
      default:
      begin
        s_d.phase = APS_PH_RUN;
      end
    endcase
    // Commit a write; a software set beats the supply clear
    if (do_write)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.awaddr) ? APS_RESP_OKAY : APS_RESP_SLVERR;
      case (s_q.awaddr)
        APS_LOW_POWER_CONTROL:
        begin
          s_d.lpc = merge(s_d.lpc, s_q.wdata, s_q.wstrb, APS_LPC_WRITE_MASK);
        end
        APS_GPIO0_WAKE_ENABLE:
        begin
          s_d.wake_en = merge(s_q.wake_en, s_q.wdata, s_q.wstrb, APS_GPIO0_PRESENT);
        end
        default:
        begin
          s_d.wake_en = s_q.wake_en;
        end
      endcase
    end
    // Write response taken
    if (s_q.bvalid && axi_req.bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // Read response taken
    if (s_q.rvalid && axi_req.rready)
    begin
      s_d.rvalid = 1'b0;
    end
    // Read taken: data registered with rvalid
    if (do_read)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = mapped(raddr) ? APS_RESP_OKAY : APS_RESP_SLVERR;
      case (raddr)
        APS_LOW_POWER_CONTROL:
        begin
          s_d.rdata = s_q.lpc;
        end
        APS_GPIO0_WAKE_FLAGS:
        begin
          s_d.rdata = pin_wake_flags;
        end
        APS_GPIO0_WAKE_ENABLE:
        begin
          s_d.rdata = s_q.wake_en;
        end
        default:
        begin
          s_d.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Only power-on reset here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.lpc <= APS_LPC_RESET;
      s_q.wake_en <= APS_WAKE_RESET;
      s_q.phase <= APS_PH_DETECT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Bus outputs
  // ************************************************************
  always_comb
  begin
    axi_rsp = '0;
    axi_rsp.awready = !s_q.aw_have && !s_q.bvalid;
    axi_rsp.wready = !s_q.w_have && !s_q.bvalid;
    axi_rsp.bvalid = s_q.bvalid;
    axi_rsp.bresp = s_q.bresp;
    axi_rsp.arready = !s_q.rvalid;
    axi_rsp.rvalid = s_q.rvalid;
    axi_rsp.rdata = s_q.rdata;
    axi_rsp.rresp = s_q.rresp;
  end

  // ************************************************************
  // Control outputs
  // ************************************************************
  always_comb
  begin
    ctrl = '0;
    ctrl.crystal_osc_powerdown = lpc[APS_CRYSTAL_OSC_POWERDOWN];
    ctrl.crystal_keep_in_sleep = lpc[APS_CRYSTAL_KEEP] && !lpc[APS_STORAGE_EN];
    ctrl.lfo_keep_in_sleep = lpc[APS_LFO_KEEP] && !lpc[APS_STORAGE_EN];
    ctrl.lfo_force_off = lpc[APS_STORAGE_EN];
    ctrl.io_monitor_off = lpc[APS_IO_MON_OFF];
    ctrl.analog_monitor_off = lpc[APS_ANALOG_MON_OFF];
    ctrl.core_monitor_off = lpc[APS_CORE_MON_OFF] && !lpc[APS_BANDGAP_OFF_IN_SLEEP];
    ctrl.baud_rate_oscillator_off = lpc[APS_CORE_MON_OFF] && !lpc[APS_BANDGAP_OFF_IN_SLEEP];
    ctrl.core_ext_supply = lpc[APS_CORE_EXT_SUPPLY];
    ctrl.regulator_off = lpc[APS_REGULATOR_OFF];
    ctrl.core_por_cut = lpc[APS_CORE_POR_CUT] && (mode.deep_sleep_mode || mode.mode_a_active);
    ctrl.bandgap_off = lpc[APS_BANDGAP_OFF_IN_SLEEP] && mode.deep_sleep_mode;
    ctrl.skip_lfo_warmup = lpc[APS_FAST_WAKE];
    ctrl.short_warmup = lpc[APS_FAST_WAKE];
    ctrl.resume_next = lpc[APS_FAST_WAKE];
    ctrl.reset_on_exit = !lpc[APS_FAST_WAKE];
    ctrl.enter_storage = mode.mode_a_request && lpc[APS_STORAGE_EN];
    ctrl.enter_mode_a = mode.mode_a_request && !lpc[APS_STORAGE_EN];
    ctrl.ret_supply_sel = lpc[APS_RET_SUPPLY_SEL];
    ctrl.detect_bypass = lpc[APS_DET_BYPASS];
    ctrl.core_range = lpc[APS_RANGE_LSB +: 2];
    // Pair i keeps banks i and i+4; bank 0 is never kept, so pair 0 keeps bank 4 only
    ctrl.bank_keep = {lpc[APS_KEEP_LSB +: 4], lpc[APS_KEEP_LSB +: 4]};
    ctrl.bank_keep[0] = 1'b0;
  end
endmodule : aps_regs
`default_nettype wire

/* design/aps_sync.sv */
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module aps_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous pins in, stable copy out
  input wire logic [31:0] pin_async,
  output logic [31:0] pin_sync
);
  import aps_pkg::*;

  aps_sync_state_t s_q; // Both stages
  aps_sync_state_t s_d; // Next value

  // ************************************************************
  // Stage logic
  // ************************************************************
  // First stage feeds only the second
  always_comb
  begin
    s_d = s_q;
    s_d.meta = pin_async;
    s_d.stable = s_q.meta;
  end

  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pin_sync = s_q.stable;
endmodule : aps_sync
`default_nettype wire

/* design/aps_wake.sv */
// Pin-transition wake flags with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module aps_wake (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Synchronised pins and mode
  input wire logic [31:0] pins,
  input wire logic low_power_active,
  // Software clear and enables
  input wire logic [31:0] clear_bits,
  input wire logic [31:0] enable_bits,
  // Flags and wake
  output logic [31:0] pin_wake_flags,
  output logic wake
);
  import aps_pkg::*;

  aps_wake_state_t s_q; // Previous pins and flags
  aps_wake_state_t s_d; // Next value
  logic [31:0] edge_hit; // Transition this cycle

  // ************************************************************
  // Flag logic
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.prev = pins;
    edge_hit = (pins ^ s_q.prev) & {32{low_power_active}} & APS_GPIO0_PRESENT;
    s_d.flags = (s_q.flags & ~clear_bits) | edge_hit;
  end

  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pin_wake_flags = s_q.flags;
  assign wake = |(s_q.flags & enable_bits & APS_GPIO0_PRESENT);
endmodule : aps_wake
`default_nettype wire

/* verification/aps_regs_props.sv */
// Checker for the power sequencer register block ports
`timescale 1ns/1ps
`default_nettype none
module aps_regs_chk (
  // Clock and power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire aps_pkg::aps_axi_req_t axi_req,
  input wire aps_pkg::aps_axi_rsp_t axi_rsp,
  // Mode and pins
  input wire aps_pkg::aps_mode_t mode,
  input wire logic [31:0] gpio0_pins,
  input wire logic core_supply_present,
  // Controls and wake
  input wire aps_pkg::aps_ctrl_t ctrl,
  input wire logic pin_wake
);
  import aps_pkg::*;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_val;
    $rose(aresetn) |-> ctrl.crystal_osc_powerdown && ctrl.ret_supply_sel && ctrl.core_range == 2'b10
      && ctrl.bank_keep == 8'h00 && ctrl.reset_on_exit && !pin_wake;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("controls not at reset values");
  property p_det_clear;
    $rose(aresetn) && !core_supply_present |-> ##[1:10] !ctrl.regulator_off;
  endproperty
  a_det_clear: assert property (p_det_clear) else $error("regulator bit not cleared");
  property p_det_keep;
    $rose(aresetn) && core_supply_present |-> ctrl.regulator_off [*8];
  endproperty
  a_det_keep: assert property (p_det_keep) else $error("regulator bit dropped");
  property p_storage;
    mode.mode_a_request |-> ctrl.enter_storage != ctrl.enter_mode_a && ctrl.enter_storage == ctrl.lfo_force_off;
  endproperty
  a_storage: assert property (p_storage) else $error("storage redirect wrong");
  property p_lfo;
    ctrl.lfo_force_off |-> !ctrl.lfo_keep_in_sleep && !ctrl.crystal_keep_in_sleep;
  endproperty
  a_lfo: assert property (p_lfo) else $error("keep bits not overridden");
  property p_fastwk;
    ctrl.resume_next != ctrl.reset_on_exit && ctrl.skip_lfo_warmup == ctrl.resume_next
      && ctrl.short_warmup == ctrl.resume_next;
  endproperty
  a_fastwk: assert property (p_fastwk) else $error("fast wake outputs disagree");
  property p_bank;
    !ctrl.bank_keep[0] && ctrl.bank_keep[7:5] == ctrl.bank_keep[3:1];
  endproperty
  a_bank: assert property (p_bank) else $error("bank keep pairing wrong");
  property p_bgap;
    !mode.deep_sleep_mode |-> !ctrl.bandgap_off;
  endproperty
  a_bgap: assert property (p_bgap) else $error("bandgap off outside deep sleep");
  property p_por_cut;
    ctrl.core_por_cut |-> mode.deep_sleep_mode || mode.mode_a_active;
  endproperty
  a_por_cut: assert property (p_por_cut) else $error("core reset cut while active");
  property p_coremon;
    (ctrl.core_monitor_off == ctrl.baud_rate_oscillator_off)
      and (ctrl.core_monitor_off && mode.deep_sleep_mode |-> !ctrl.bandgap_off);
  endproperty
  a_coremon: assert property (p_coremon) else $error("core monitor gating wrong");
  property p_rd;
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule : aps_regs_chk
`default_nettype wire

/* verification/test_aps_regs.sv */
// Self-checking bench for the power sequencer register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_aps_regs;
  import aps_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic core_present = 1'b1;
  logic [31:0] pins = 32'h00000000;
  logic wake;
  aps_axi_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
  aps_axi_rsp_t rsp;
  aps_mode_t md = '0;
  aps_ctrl_t ctrl;
  logic [31:0] rd;
  logic [1:0] rr;
  int fail_count = 0;
  int checked = 0;
  // Clock of 20 ns
  always #10 aclk = ~aclk;
  aps_regs u_aps_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(req),
    .axi_rsp(rsp),
    .mode(md),
    .gpio0_pins(pins),
    .core_supply_present(core_present),
    .ctrl(ctrl),
    .pin_wake(wake)
  );
  // ************************************************************
  // Bus tasks
  // ************************************************************
  // Verdict and end of run
  task summarize();
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // One write, waits for the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= {24'h0, a};
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (!aw && !w && rsp.bvalid === 1'b1)
        break;
      if (aw && rsp.awready === 1'b1)
      begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1)
      begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    rr = rsp.bresp;
    // Hung write counts as a mismatch
    if (n >= 40)
    begin
      fail_count++;
      summarize();
    end
  endtask : wr
  // One read, waits for the data
  task automatic rdw(input logic [7:0] a);
    int n;
    logic ar;
    ar = 1'b1;
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (!ar && rsp.rvalid === 1'b1)
        break;
      if (ar && rsp.arready === 1'b1)
      begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end
    rd = rsp.rdata;
    rr = rsp.rresp;
    if (n >= 40)
    begin
      fail_count++;
      summarize();
    end
  endtask : rdw
  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset values with a core supply present
  task t_reset();
    rdw(APS_LOW_POWER_CONTROL);
    `CHK("lpc_rst", 32'h80011920, rd)
    rdw(APS_GPIO0_WAKE_FLAGS);
    `CHK("flags_rst", 32'h0, rd)
    rdw(APS_GPIO0_WAKE_ENABLE);
    `CHK("en_rst", 32'h0, rd)
  endtask : t_reset
  // Control fields against the mode inputs
  task t_ctrl();
    wr(APS_LOW_POWER_CONTROL, 32'hffffffff);
    rdw(APS_LOW_POWER_CONTROL);
    `CHK("lpc_rw", ~32'h4dace080, rd)
    `CHK("ext", 1'b1, ctrl.core_ext_supply)
    md.deep_sleep_mode <= 1'b1;
    md.mode_a_request <= 1'b1;
    @(posedge aclk);
    `CHK("bgap", 1'b1, ctrl.bandgap_off)
    `CHK("por", 1'b1, ctrl.core_por_cut)
    `CHK("cmon", 1'b0, ctrl.core_monitor_off)
    `CHK("store", 2'b10, {ctrl.enter_storage, ctrl.enter_mode_a})
    `CHK("keep", 3'b001, {ctrl.crystal_keep_in_sleep, ctrl.lfo_keep_in_sleep, ctrl.lfo_force_off})
    `CHK("banks", 8'hfe, ctrl.bank_keep)
    `CHK("mons", 2'b11, {ctrl.io_monitor_off, ctrl.analog_monitor_off})
    wr(APS_LOW_POWER_CONTROL, 32'h30100000);
    `CHK("xtal", 1'b0, ctrl.crystal_osc_powerdown)
    `CHK("keep2", 3'b110, {ctrl.crystal_keep_in_sleep, ctrl.lfo_keep_in_sleep, ctrl.lfo_force_off})
    `CHK("cmon2", 2'b11, {ctrl.core_monitor_off, ctrl.baud_rate_oscillator_off})
    `CHK("store2", 2'b01, {ctrl.enter_storage, ctrl.enter_mode_a})
    `CHK("bgap2", 2'b00, {ctrl.bandgap_off, ctrl.core_por_cut})
    `CHK("exit", 1'b1, ctrl.reset_on_exit)
    `CHK("ret", 1'b0, ctrl.ret_supply_sel)
    md <= '0;
  endtask : t_ctrl
  // Every core range code with fast wake and bypass
  task t_range();
    for (int i = 0; i < 4; i++)
    begin
      wr(APS_LOW_POWER_CONTROL, 32'(32'h440 + i * 16));
      rdw(APS_LOW_POWER_CONTROL);
      `CHK("range_rd", 32'(32'h440 + i * 16), rd)
      `CHK("range", 2'(i), ctrl.core_range)
      `CHK("fast", 3'b110, {ctrl.detect_bypass, ctrl.resume_next, ctrl.reset_on_exit})
      `CHK("warm", 2'b11, {ctrl.skip_lfo_warmup, ctrl.short_warmup})
    end
  endtask : t_range
  // Pin edges, write-one-clear and wake gating
  task t_wake();
    wr(APS_GPIO0_WAKE_ENABLE, 32'h5);
    rdw(APS_GPIO0_WAKE_ENABLE);
    `CHK("en", 32'h5, rd)
    pins <= 32'h1;
    repeat (6) @(posedge aclk);
    rdw(APS_GPIO0_WAKE_FLAGS);
    `CHK("idle_edge", 32'h0, rd)
    md.low_power_active <= 1'b1;
    pins <= 32'h2;
    repeat (6) @(posedge aclk);
    rdw(APS_GPIO0_WAKE_FLAGS);
    `CHK("both_edges", 32'h3, rd)
    `CHK("wake", 1'b1, wake)
    wr(APS_GPIO0_WAKE_FLAGS, 32'h1);
    rdw(APS_GPIO0_WAKE_FLAGS);
    `CHK("w1c", 32'h2, rd)
    `CHK("masked", 1'b0, wake)
    wr(APS_GPIO0_WAKE_FLAGS, 32'h0);
    rdw(APS_GPIO0_WAKE_FLAGS);
    `CHK("w0", 32'h2, rd)
    wr(APS_GPIO0_WAKE_ENABLE, 32'h2);
    `CHK("wake2", 1'b1, wake)
    wr(APS_GPIO0_WAKE_FLAGS, 32'hffffffff);
    `CHK("wake_off", 1'b0, wake)
    md.low_power_active <= 1'b0;
  endtask : t_wake
  // Unmapped and listed-only addresses
  task t_map();
    rdw(8'h20);
    `CHK("unm_rd", 34'h200000000, {rr, rd})
    wr(8'h20, 32'h1);
    `CHK("unm_wr", 2'h2, rr)
    wr(APS_SCRATCH_WORD_A, 32'h5a5a5a5a);
    `CHK("list_wr", 2'h0, rr)
    rdw(APS_SCRATCH_WORD_A);
    `CHK("list_rd", 34'h0, {rr, rd})
  endtask : t_map
  // Second power-on reset without a core supply
  task t_por();
    wr(APS_GPIO0_WAKE_ENABLE, 32'hf);
    aresetn <= 1'b0;
    core_present <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    rdw(APS_LOW_POWER_CONTROL);
    `CHK("det", 32'h80001920, rd)
    `CHK("reg_on", 1'b0, ctrl.regulator_off)
    rdw(APS_GPIO0_WAKE_ENABLE);
    `CHK("por_en", 32'h0, rd)
    wr(APS_LOW_POWER_CONTROL, 32'h80011920);
    rdw(APS_LOW_POWER_CONTROL);
    `CHK("reg_set", 32'h80011920, rd)
    md.mode_a_active <= 1'b1;
    @(posedge aclk);
    `CHK("por_a", 2'b10, {ctrl.core_por_cut, ctrl.bandgap_off})
    md <= '0;
  endtask : t_por
  // Main sequence
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ctrl();
    t_range();
    t_wake();
    t_map();
    t_por();
    summarize();
  end
endmodule : test_aps_regs
bind aps_regs aps_regs_chk u_aps_regs_chk (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .mode(mode),
  .gpio0_pins(gpio0_pins), .core_supply_present(core_supply_present), .ctrl(ctrl), .pin_wake(pin_wake)
);
`default_nettype wire
